// file: rtl/vms_pkg.sv
package vms_pkg;

    // -------------------------------------------------------------
    // Geometry
    // -------------------------------------------------------------
    localparam int VMS_PAGE_BYTES = 2048;
    localparam int VMS_PAGES_PER_SEG = 16;
    localparam int VMS_CONTEXTS = 8;
    localparam int VMS_CTX_W = 3;
    localparam int VMS_SEG_IDX_W = VMS_CTX_W + 9;
    localparam int VMS_PMEG_W = 8;
    localparam int VMS_PAGE_IDX_W = VMS_PMEG_W + 4;
    localparam int VMS_PHYS_PAGE_W = 12;

    // -------------------------------------------------------------
    // Page entry layout
    // -------------------------------------------------------------
    localparam int VMS_PE_PROT_LSB = 18;
    localparam int VMS_PE_TYPE_LSB = 16;
    localparam int VMS_PE_W = 24;

    // -------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [7:0] VMS_OFF_CTRL = 8'h00;
    localparam logic [7:0] VMS_OFF_CTX = 8'h04;
    localparam logic [7:0] VMS_OFF_SEG = 8'h08;
    localparam logic [7:0] VMS_OFF_PAGE = 8'h0C;
    localparam logic [7:0] VMS_OFF_XLAT = 8'h10;
    localparam logic [7:0] VMS_OFF_STAT = 8'h14;
    localparam logic [7:0] VMS_OFF_MAPWIN = 8'h18;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam real VMS_REFRESH_NS = 12800.0;
    localparam real VMS_CLK_NS = 10.0;
    localparam int VMS_REFRESH_CYC = int'(VMS_REFRESH_NS / VMS_CLK_NS);
    localparam int VMS_XFER_CYC = 4;

    // Request source indices
    localparam int VMS_SRC_REF = 0;
    localparam int VMS_SRC_NET = 1;
    localparam int VMS_SRC_BPL = 2;

    // Controller states
    typedef enum logic [1:0] {
        VMS_IDLE,
        VMS_REQ,
        VMS_XFER
    } vms_state_t;

    // Memory side strobes
    typedef struct packed {
        logic [7:0] bank_column_strobes;
        logic row_strobe;
        logic lower_byte_write_strobe;
        logic upper_byte_write_strobe;
        logic [7:0] ram_addr;
        logic memory_select;
        logic read_buffer_enable;
        logic write_buffer_enable;
    } vms_mem_t;

    // Module state apart from the two maps
    typedef struct packed {
        logic [2:0] user_ctx;
        logic [2:0] sup_ctx;
        logic [1:0] section_cfg;
        logic [11:0] seg_addr;
        logic [11:0] page_addr;
        logic [23:0] virt_addr;
        logic fc_super;
        logic fc_write;
        logic fc_special;
        logic protection_violation;
        logic [1:0] upd_type;
        logic upd_pend;
        logic [11:0] upd_idx;
        logic [22:0] phys_addr;
        logic [2:0] req;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2:0] sync_c;
        logic [1:0] grant_sync_a;
        logic [1:0] grant_sync_b;
        logic [1:0] grant_sync_c;
        vms_state_t st;
        logic [1:0] winner;
        logic [2:0] xfer_cnt;
        logic [10:0] ref_cnt;
        logic [7:0] ref_row;
        logic [31:0] prdata;
        logic rd_hold; // Read data loaded, answer this cycle
    } vms_state_s_t;

    // Three bits of the write word decode to map selects
    function automatic logic [2:0] vms_map_dec(input logic [2:0] a);
        vms_map_dec = {a == 3'h4, a == 3'h2, a == 3'h1};
    endfunction : vms_map_dec

endpackage : vms_pkg

// file: rtl/vms_top.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module vms_top
    import vms_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic protection_violation,
    output logic [22:0] phys_addr,
    output vms_mem_t mem,
    input wire logic refresh_unused,
    input wire logic network_data_strobe,
    input wire logic backplane_request,
    output logic processor_bus_request,
    input wire logic processor_bus_grant,
    input wire logic processor_address_strobe,
    output logic refresh_access_enable,
    output logic network_access_enable,
    output logic backplane_access_enable,
    output logic bank_pair_enable_low,
    output logic bank_pair_enable_high,
    output logic refresh_access_request
);

    // -------------------------------------------------------------
    // Maps
    // -------------------------------------------------------------
    // Segment map: context plus A15-23 gives page entry group
    logic [7:0] seg_map [0:4095];
    // Page map: physical page, type, protection
    logic [23:0] page_map [0:4095];

    vms_state_s_t q;
    vms_state_s_t next_q;

    logic wr_en;
    logic rd_en;
    logic [2:0] sel;
    logic [2:0] active_ctx;
    logic [7:0] pmeg;
    logic [11:0] pidx;
    logic [23:0] pte;
    logic [5:0] prot;
    logic allowed;
    logic [2:0] pend;
    logic [2:0] edge_in;
    logic ref_tick;
    logic grant_ok;
    logic grant_seen; // Old grant still in the synchroniser
    logic [1:0] sect;
    logic sect_on;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    // Reads wait one cycle so that registered data stands at the answer
    assign pready = !rd_en || q.rd_hold;
    assign pslverr = 1'b0;
    // Map window select field rides in the write word, bits 30:28
    assign sel = vms_map_dec(pwdata[30:28]);

    // -------------------------------------------------------------
    // Translation path
    // -------------------------------------------------------------
    always_comb begin
        // Function code chooses context
        active_ctx = q.fc_super ? q.sup_ctx : q.user_ctx;
        pmeg = seg_map[{active_ctx, q.virt_addr[23:15]}];
        pidx = {pmeg, q.virt_addr[14:11]};
        pte = page_map[pidx];
        prot = pte[VMS_PE_PROT_LSB +: 6];
        // Bits 5..3 supervisor rwx, 2..0 user rwx
        if (q.fc_super) begin
            allowed = q.fc_write ? prot[4] : prot[5];
        end else begin
            allowed = q.fc_write ? prot[1] : prot[2];
        end
        // Section decode on physical bits 20-22
        sect = q.phys_addr[21:20];
        unique case (sect)
            2'h0: sect_on = 1'b1;
            2'h1: sect_on = q.section_cfg[0];
            default: sect_on = q.section_cfg[1];
        endcase
        if (q.phys_addr[22]) begin
            sect_on = 1'b0;
        end
    end

    // Synchronized rising edges of outside strobes
    assign edge_in = q.sync_b & ~q.sync_c;
    assign ref_tick = q.ref_cnt == 11'(VMS_REFRESH_CYC - 1);
    // Grant seen and address strobe released
    assign grant_ok = q.grant_sync_b[0] && q.grant_sync_c[0]
        && !q.grant_sync_b[1] && !q.grant_sync_c[1];
    // A grant from the previous transfer must drain before a new request
    assign grant_seen = q.grant_sync_a[0] || q.grant_sync_b[0]
        || q.grant_sync_c[0];
    assign pend = q.req;

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.sync_a = {backplane_request, network_data_strobe, 1'b0};
        next_q.sync_b = q.sync_a;
        next_q.sync_c = q.sync_b;
        next_q.grant_sync_a = {processor_address_strobe,
            processor_bus_grant};
        next_q.grant_sync_b = q.grant_sync_a;
        next_q.grant_sync_c = q.grant_sync_b;
        // Refresh timer
        next_q.ref_cnt = ref_tick ? 11'h000 : q.ref_cnt + 11'h001;
        // Request flip-flops: set beats clear
        next_q.req = q.req | {edge_in[2:1], ref_tick};
        // Translation and protection
        next_q.protection_violation = !allowed && !q.fc_special;
        next_q.phys_addr = {pte[11:0], q.virt_addr[10:0]};
        // Access type rewrite on non-special cycles
        next_q.upd_pend = !q.fc_special;
        next_q.upd_idx = pidx;
        next_q.upd_type = {1'b1, q.fc_write};
        next_q.prdata = q.prdata;
        next_q.rd_hold = rd_en && !q.rd_hold;
        if (wr_en) begin
            unique case (paddr)
                VMS_OFF_CTRL: next_q.section_cfg = pwdata[1:0];
                VMS_OFF_CTX: begin
                    next_q.user_ctx = pwdata[2:0];
                    next_q.sup_ctx = pwdata[6:4];
                end
                VMS_OFF_SEG: next_q.seg_addr = pwdata[11:0];
                VMS_OFF_PAGE: next_q.page_addr = pwdata[11:0];
                VMS_OFF_XLAT: begin
                    next_q.virt_addr = pwdata[23:0];
                    next_q.fc_super = pwdata[24];
                    next_q.fc_write = pwdata[25];
                    next_q.fc_special = pwdata[26];
                end
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (paddr)
                VMS_OFF_CTRL: next_q.prdata = {30'h0, q.section_cfg};
                VMS_OFF_CTX:
                    next_q.prdata = {25'h0, q.sup_ctx, 1'b0, q.user_ctx};
                VMS_OFF_XLAT: next_q.prdata = {9'h0, q.phys_addr};
                VMS_OFF_STAT: next_q.prdata = {24'h0, 1'b0,
                    q.protection_violation, q.req, 1'b0, q.winner};
                default: next_q.prdata = 32'h0000_0000;
            endcase
        end
        // Controller
        unique case (q.st)
            VMS_IDLE: begin
                if (pend != 3'h0 && !grant_seen) begin
                    next_q.st = VMS_REQ;
                    if (pend[VMS_SRC_REF]) begin
                        next_q.winner = 2'h0;
                    end else if (pend[VMS_SRC_NET]) begin
                        next_q.winner = 2'h1;
                    end else begin
                        next_q.winner = 2'h2;
                    end
                end
            end
            VMS_REQ: begin
                if (grant_ok) begin
                    next_q.st = VMS_XFER;
                    next_q.xfer_cnt = 3'h0;
                end
            end
            VMS_XFER: begin
                next_q.xfer_cnt = q.xfer_cnt + 3'h1;
                if (q.xfer_cnt == 3'(VMS_XFER_CYC - 1)) begin
                    next_q.st = VMS_IDLE;
                    next_q.req[q.winner] = 1'b0;
                    if (q.winner == 2'h0) begin
                        next_q.ref_row = q.ref_row + 8'h01;
                    end
                    // A new request edge or tick still wins over clear
                    next_q.req = next_q.req | {edge_in[2:1], ref_tick};
                end
            end
            default: next_q.st = VMS_IDLE;
        endcase
    end

    // -------------------------------------------------------------
    // Map writes, register
    // -------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == VMS_OFF_MAPWIN && sel[0]) begin
            seg_map[q.seg_addr] <= pwdata[7:0];
        end
        if (wr_en && paddr == VMS_OFF_MAPWIN && sel[1]) begin
            page_map[q.page_addr] <= pwdata[23:0];
        end else if (q.upd_pend) begin
            page_map[q.upd_idx][VMS_PE_TYPE_LSB +: 2] <= q.upd_type;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    always_comb begin
        mem = '0;
        mem.memory_select = sect_on;
        mem.read_buffer_enable = sect_on && !q.fc_write;
        mem.write_buffer_enable = sect_on && q.fc_write;
        mem.ram_addr = q.phys_addr[8:1];
        mem.row_strobe = sect_on;
        mem.bank_column_strobes = sect_on ?
            (8'h01 << q.phys_addr[19:17]) : 8'h00;
        mem.lower_byte_write_strobe = sect_on && q.fc_write;
        mem.upper_byte_write_strobe = sect_on && q.fc_write;
        if (refresh_access_enable) begin
            mem.ram_addr = q.ref_row;
            mem.row_strobe = 1'b1;
            mem.bank_column_strobes = 8'h00;
        end
    end

    assign prdata = q.prdata;
    assign protection_violation = q.protection_violation;
    assign phys_addr = q.phys_addr;
    assign processor_bus_request = q.st != VMS_IDLE;
    assign refresh_access_enable = q.st == VMS_XFER && q.winner == 2'h0;
    assign network_access_enable = q.st == VMS_XFER && q.winner == 2'h1;
    assign backplane_access_enable = q.st == VMS_XFER && q.winner == 2'h2;
    assign bank_pair_enable_low = refresh_access_enable;
    assign bank_pair_enable_high = refresh_access_enable;
    assign refresh_access_request = q.req[VMS_SRC_REF];

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    property p_release;
        @(posedge pclk) disable iff (!presetn)
        q.st == VMS_XFER && q.xfer_cnt == 3'h3 |=> !processor_bus_request;
    endproperty
    a_release: assert property (p_release) else $error("no release");

    property p_refresh_banks;
        @(posedge pclk) disable iff (!presetn)
        refresh_access_enable |-> bank_pair_enable_low
            && bank_pair_enable_high && mem.row_strobe;
    endproperty
    a_refresh_banks: assert property (p_refresh_banks)
        else $error("refresh banks");

    property p_req;
        @(posedge pclk) disable iff (!presetn)
        q.st == VMS_IDLE && pend != 3'h0 && !grant_seen
            |=> processor_bus_request;
    endproperty
    a_req: assert property (p_req) else $error("no bus request");

    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        q.st == VMS_IDLE && pend[0] && !grant_seen |=> q.winner == 2'h0;
    endproperty
    a_prio: assert property (p_prio) else $error("bad priority");

    property p_grant;
        @(posedge pclk) disable iff (!presetn)
        q.st == VMS_REQ && !grant_ok |=> q.st != VMS_XFER;
    endproperty
    a_grant: assert property (p_grant) else $error("early take");

    property p_tick;
        @(posedge pclk) disable iff (!presetn)
        ref_tick |=> q.req[0];
    endproperty
    a_tick: assert property (p_tick) else $error("lost refresh");

    property p_sect;
        @(posedge pclk) disable iff (!presetn)
        !sect_on |-> mem.bank_column_strobes == 8'h00 || q.st == VMS_XFER;
    endproperty
    a_sect: assert property (p_sect) else $error("bad select");

    property p_net;
        @(posedge pclk) disable iff (!presetn)
        edge_in[1] |=> q.req[1];
    endproperty
    a_net: assert property (p_net) else $error("lost network req");

endmodule : vms_top

// file: test/vms_cpu_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Processor side of the bus handover
// ------------------------------------------------------------
module vms_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic processor_bus_request,
    input wire logic [3:0] grant_delay,
    output logic processor_bus_grant,
    output logic processor_address_strobe
);
    logic [3:0] wait_cnt; // Cycles already spent in own bus cycle

    // Own cycles keep the strobe moving, so a stale level never helps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 4'h0;
            processor_bus_grant <= 1'b0;
            processor_address_strobe <= 1'b1;
        end else if (!processor_bus_request) begin
            // Bus back with the processor
            wait_cnt <= 4'h0;
            processor_bus_grant <= 1'b0;
            processor_address_strobe <= ~processor_address_strobe;
        end else if (wait_cnt < grant_delay) begin
            // Finishing its own cycle first; skipped when grant_delay is 0
            wait_cnt <= wait_cnt + 4'h1;
            processor_address_strobe <= ~processor_address_strobe;
        end else begin
            // Strobe dropped and grant given together
            processor_address_strobe <= 1'b0;
            processor_bus_grant <= 1'b1;
        end
    end
endmodule : vms_cpu_model

// file: test/virtual_memory_subsystem_bench.sv
`timescale 1ns/1ps
module virtual_memory_subsystem_bench;
    import vms_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic net_strobe = 1'b0; // Network data strobe
    logic bpl_req = 1'b0; // Backplane request
    logic bus_req;
    logic bus_grant;
    logic addr_strobe;
    logic ref_en;
    logic net_en;
    logic bpl_en;
    logic bank_lo;
    logic bank_hi;
    logic ref_req;
    logic prot_err; // Protection violation
    vms_mem_t mem_o; // Memory side strobes
    logic [3:0] grant_delay = 4'h0; // Processor handover latency
    logic [2:0] en; // Enables, backplane down to refresh
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0; // Free cycle count

    assign en = {bpl_en, net_en, ref_en};

    // Clock of 10 ns
    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
    end

    // ------------------------------------------------------------
    // Design and processor model
    // ------------------------------------------------------------
    vms_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .protection_violation(prot_err), .phys_addr(),
        .mem(mem_o), .refresh_unused(1'b0),
        .network_data_strobe(net_strobe),
        .backplane_request(bpl_req), .processor_bus_request(bus_req),
        .processor_bus_grant(bus_grant),
        .processor_address_strobe(addr_strobe),
        .refresh_access_enable(ref_en), .network_access_enable(net_en),
        .backplane_access_enable(bpl_en), .bank_pair_enable_low(bank_lo),
        .bank_pair_enable_high(bank_hi), .refresh_access_request(ref_req));

    vms_cpu_model cpu_u (.pclk(pclk), .presetn(presetn),
        .processor_bus_request(bus_req), .grant_delay(grant_delay),
        .processor_bus_grant(bus_grant),
        .processor_address_strobe(addr_strobe));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // One APB transfer; ready and data sampled settled before each edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        logic rdy;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(negedge pclk);
            rdy = pready;
            q = prdata;
            n++;
            @(posedge pclk);
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            miscompares++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so the next call never re-raises in this step
        @(posedge pclk);
    endtask : apb

    // Waits for a transfer, judges its winner and its length
    task automatic xfer(input logic [2:0] want);
        int n;
        int len;
        n = 0;
        len = 0;
        @(negedge pclk);
        while (en === 3'b000 && n < 80) begin
            n++;
            @(negedge pclk);
        end
        check(32'(en), 32'(want), "winner");
        check(32'(bus_req), 32'h1, "request held");
        check(32'({bank_hi, bank_lo}), want == 3'b001 ? 32'h3 : 32'h0,
            "bank pair");
        while (en !== 3'b000 && len < 20) begin
            len++;
            @(negedge pclk);
        end
        check(32'(len), 32'(VMS_XFER_CYC), "transfer length");
        @(posedge pclk);
    endtask : xfer

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] q;
        check(32'({pready, pslverr, bus_req}), 32'h4, "idle outputs");
        apb(1'b1, VMS_OFF_CTX, 32'h53, q);
        apb(1'b0, VMS_OFF_CTX, 32'h0, q);
        check(q, 32'h53, "context readback");
        apb(1'b1, VMS_OFF_CTRL, 32'h3, q);
        apb(1'b0, VMS_OFF_CTRL, 32'h0, q);
        check(q, 32'h3, "section config");
        apb(1'b1, 8'h40, 32'hFFFF, q);
        apb(1'b0, 8'h40, 32'h0, q);
        check(q, 32'h0, "unmapped read");
    endtask : t_regs

    // User context 3, page 1 of segment 0 mapped to physical page 123
    task automatic t_xlat;
        logic [31:0] q;
        apb(1'b1, VMS_OFF_SEG, 32'h600, q);
        apb(1'b1, VMS_OFF_MAPWIN, 32'h1000_0005, q);
        apb(1'b1, VMS_OFF_PAGE, 32'h51, q);
        apb(1'b1, VMS_OFF_MAPWIN, 32'h2010_0123, q);
        apb(1'b1, VMS_OFF_XLAT, 32'h800, q);
        apb(1'b0, VMS_OFF_XLAT, 32'h0, q);
        check(q, 32'h0009_1800, "translated address");
        @(negedge pclk);
        check(32'(prot_err), 32'h0, "user read allowed");
        check(32'({mem_o.memory_select, mem_o.bank_column_strobes}),
            32'h110, "section and bank");
        @(posedge pclk);
        apb(1'b1, VMS_OFF_XLAT, 32'h0200_0800, q);
        @(negedge pclk);
        check(32'(prot_err), 32'h1, "user write refused");
        @(posedge pclk);
    endtask : t_xlat

    // Two refresh requests: period, enables and bank pair
    task automatic t_refresh;
        int n;
        int t0;
        n = 0;
        @(negedge pclk);
        while (ref_req !== 1'b1 && n < 1400) begin
            n++;
            @(negedge pclk);
        end
        t0 = cyc;
        xfer(3'b001);
        n = 0;
        @(negedge pclk);
        while (ref_req !== 1'b1 && n < 1400) begin
            n++;
            @(negedge pclk);
        end
        check(32'(cyc - t0), 32'(VMS_REFRESH_CYC), "refresh period");
        xfer(3'b001);
    endtask : t_refresh

    // Lone network request against a slow processor
    task automatic t_net;
        int n;
        n = 0;
        grant_delay <= 4'h6;
        net_strobe <= 1'b1;
        repeat (2) @(posedge pclk);
        net_strobe <= 1'b0;
        xfer(3'b010);
        @(negedge pclk);
        while (bus_req !== 1'b0 && n < 4) begin
            n++;
            @(negedge pclk);
        end
        check(32'(bus_req), 32'h0, "bus released");
        @(posedge pclk);
    endtask : t_net

    // Network and backplane together, prompt processor
    task automatic t_prio;
        grant_delay <= 4'h0;
        net_strobe <= 1'b1;
        bpl_req <= 1'b1;
        repeat (2) @(posedge pclk);
        net_strobe <= 1'b0;
        bpl_req <= 1'b0;
        xfer(3'b010);
        xfer(3'b100);
    endtask : t_prio

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_xlat();
        t_refresh(); // DMA tests follow right after a refresh
        t_net();
        t_prio();
        print_verdict();
    end

    // Refresh waits dominate, about 3000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end
endmodule : virtual_memory_subsystem_bench
